// >>> logic/tcr_edge.sv
// Pin synchroniser and falling-edge detector.
`timescale 1ns/1ps

module tcr_edge (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      fall
);
    tcr_pkg::tcr_edge_st_t st;
    tcr_pkg::tcr_edge_st_t next_st;

    always_comb begin
        next_st       = st;
        next_st.sync1 = pin;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
        next_st.fall  = st.prev & ~st.sync2;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fall = st.fall;

    property p_fall_shape;
        @(posedge clock) disable iff (!rstn)
        fall |-> $past(st.prev) && !$past(st.sync2);
    endproperty
    a_fall_shape: assert property (p_fall_shape) else $error("edge pulse without 1-to-0");
endmodule

// >>> logic/tcr_map.svh
// Register indices, field positions, reset values and codes of the timer block.
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH

`define TCR_AW           12
`define TCR_IDX_HI       11
`define TCR_IDX_LO       2
`define TCR_IDX_W        10
`define TCR_BYTE_OFS     2'h0

`define TCR_IDX_CTRL     10'h0C8
`define TCR_IDX_RCAP_LO  10'h0CA
`define TCR_IDX_RCAP_HI  10'h0CB
`define TCR_IDX_CNT_LO   10'h0CC
`define TCR_IDX_CNT_HI   10'h0CD
`define TCR_IDX_IRQ_STAT 10'h0D0
`define TCR_IDX_IRQ_CLR  10'h0D1
`define TCR_IDX_IRQ_EN   10'h0D2

`define TCR_CTRL_RST     8'h00
`define TCR_WORD_RST     16'h0000
`define TCR_CNT_MAX      16'hFFFF
`define TCR_CNT_STEP     16'h0001
`define TCR_RDATA_PAD    24'h000000
`define TCR_IRQ_W        2
`define TCR_IRQ_OVF      0
`define TCR_IRQ_EXT      1
`define TCR_LANE0        0

`define TCR_RESP_OKAY    2'h0
`define TCR_RESP_SLVERR  2'h2

`endif

// >>> logic/tcr_pkg.sv
// Types shared by the timer block and its edge detector.
`include "tcr_map.svh"

package tcr_pkg;

    typedef struct packed {
        logic ovf_flag;
        logic ext_flag;
        logic rx_baud_select;
        logic tx_baud_select;
        logic ext_pin_enable;
        logic run_control;
        logic counter_timer_select;
        logic capture_reload_select;
    } tcr_ctrl_t;

    typedef struct packed {
        logic                 awvalid;
        logic [`TCR_AW-1:0]   awaddr;
        logic                 wvalid;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bready;
        logic                 arvalid;
        logic [`TCR_AW-1:0]   araddr;
        logic                 rready;
    } tcr_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tcr_axi_rsp_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic fall;
    } tcr_edge_st_t;

    typedef struct packed {
        tcr_ctrl_t            ctrl;
        logic [15:0]          rcap;
        logic [15:0]          cnt;
        logic                 presc;
        logic [`TCR_IRQ_W-1:0] irq_stat;
        logic [`TCR_IRQ_W-1:0] irq_en;
        logic                 irq;
        logic                 rx_baud_tick;
        logic                 tx_baud_tick;
        logic                 aw_have;
        logic                 w_have;
        logic [`TCR_AW-1:0]   awaddr;
        logic [7:0]           wbyte;
        logic                 wlane;
        tcr_axi_rsp_t         rsp;
    } tcr_st_t;

endpackage

// >>> logic/tcr_top.sv
// Sixteen-bit capture/reload timer with baud clock selection and AXI4-Lite registers.
`timescale 1ns/1ps
`include "tcr_map.svh"

module tcr_top (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire tcr_pkg::tcr_axi_req_t axi_req,
    output tcr_pkg::tcr_axi_rsp_t      axi_rsp,
    input  wire logic                  count_input_pin,
    input  wire logic                  ext_trigger_pin,
    input  wire logic                  timer1_ovf,
    output logic                       rx_baud_tick,
    output logic                       tx_baud_tick,
    output logic                       irq
);
    tcr_pkg::tcr_st_t st;
    tcr_pkg::tcr_st_t next_st;
    logic             cnt_fall;
    logic             trig_fall;
    logic             baud;
    logic             tick;
    logic             wrap;
    logic             ext_act;
    logic             do_wr;
    logic             wr_ok;
    logic             wr_ctrl;

    tcr_edge u_cnt_edge (
        .clock (clock),
        .rstn  (rstn),
        .pin   (count_input_pin),
        .fall  (cnt_fall)
    );

    tcr_edge u_trig_edge (
        .clock (clock),
        .rstn  (rstn),
        .pin   (ext_trigger_pin),
        .fall  (trig_fall)
    );

    // Baud use forces reload and disarms the trigger pin.
    assign baud    = st.ctrl.rx_baud_select | st.ctrl.tx_baud_select;
    assign tick    = st.ctrl.run_control &&
                     (st.ctrl.counter_timer_select ? cnt_fall : st.presc);
    assign wrap    = tick && (st.cnt == `TCR_CNT_MAX);
    assign ext_act = trig_fall && st.ctrl.ext_pin_enable && !baud;
    assign do_wr   = st.aw_have && st.w_have && !st.rsp.bvalid;
    assign wr_ok   = st.awaddr[1:0] == `TCR_BYTE_OFS;
    assign wr_ctrl = do_wr && wr_ok && st.wlane &&
                     st.awaddr[`TCR_IDX_HI:`TCR_IDX_LO] == `TCR_IDX_CTRL;

    always_comb begin
        logic [`TCR_IDX_W-1:0] widx;
        logic [`TCR_IDX_W-1:0] ridx;
        logic                  wmap;
        logic                  rmap;
        logic [7:0]            rbyte;
        widx    = st.awaddr[`TCR_IDX_HI:`TCR_IDX_LO];
        ridx    = axi_req.araddr[`TCR_IDX_HI:`TCR_IDX_LO];
        wmap    = 1'b1;
        rmap    = 1'b1;
        rbyte   = 8'h00;
        next_st = st;

        // Prescaler restarts when the timer stops, so the first tick comes one cycle after run is set.
        next_st.presc = st.ctrl.run_control ? !st.presc : 1'b0;

        // Write channels are taken independently and joined before the register update.
        if (axi_req.awvalid && st.rsp.awready) begin
            next_st.aw_have = 1'b1;
            next_st.awaddr  = axi_req.awaddr;
        end
        if (axi_req.wvalid && st.rsp.wready) begin
            next_st.w_have = 1'b1;
            next_st.wbyte  = axi_req.wdata[7:0];
            next_st.wlane  = axi_req.wstrb[`TCR_LANE0];
        end
        if (st.rsp.bvalid && axi_req.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        if (do_wr) begin
            case (widx)
                `TCR_IDX_CTRL, `TCR_IDX_RCAP_LO, `TCR_IDX_RCAP_HI, `TCR_IDX_CNT_LO,
                `TCR_IDX_CNT_HI, `TCR_IDX_IRQ_STAT, `TCR_IDX_IRQ_CLR,
                `TCR_IDX_IRQ_EN: wmap = wr_ok;
                default: wmap = 1'b0;
            endcase
            if (wmap && st.wlane) begin
                case (widx)
                    `TCR_IDX_CTRL: next_st.ctrl = tcr_pkg::tcr_ctrl_t'(st.wbyte);
                    `TCR_IDX_RCAP_LO: next_st.rcap[7:0] = st.wbyte;
                    `TCR_IDX_RCAP_HI: next_st.rcap[15:8] = st.wbyte;
                    `TCR_IDX_CNT_LO: next_st.cnt[7:0] = st.wbyte;
                    `TCR_IDX_CNT_HI: next_st.cnt[15:8] = st.wbyte;
                    `TCR_IDX_IRQ_CLR: next_st.irq_stat = st.irq_stat & ~st.wbyte[`TCR_IRQ_W-1:0];
                    `TCR_IDX_IRQ_EN: next_st.irq_en = st.wbyte[`TCR_IRQ_W-1:0];
                    default: next_st.irq_en = next_st.irq_en;
                endcase
            end
            next_st.aw_have    = 1'b0;
            next_st.w_have     = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp  = wmap ? `TCR_RESP_OKAY : `TCR_RESP_SLVERR;
        end

        // Hardware events come after the software write so that a set beats a clear
        // and a capture or reload beats a write landing in the same cycle.
        if (ext_act) begin
            if (st.ctrl.capture_reload_select) begin
                next_st.rcap = st.cnt;
            end else begin
                next_st.cnt = st.rcap;
            end
            next_st.ctrl.ext_flag             = 1'b1;
            next_st.irq_stat[`TCR_IRQ_EXT]    = 1'b1;
        end
        if (tick && !(ext_act && !st.ctrl.capture_reload_select)) begin
            if (wrap) begin
                next_st.cnt = (baud || !st.ctrl.capture_reload_select) ?
                              st.rcap : `TCR_WORD_RST;
            end else begin
                next_st.cnt = 16'(st.cnt + `TCR_CNT_STEP);
            end
        end
        if (wrap && !baud) begin
            next_st.ctrl.ovf_flag          = 1'b1;
            next_st.irq_stat[`TCR_IRQ_OVF] = 1'b1;
        end

        next_st.rx_baud_tick = st.ctrl.rx_baud_select ? wrap : timer1_ovf;
        next_st.tx_baud_tick = st.ctrl.tx_baud_select ? wrap : timer1_ovf;
        next_st.irq          = |(next_st.irq_stat & next_st.irq_en);

        if (st.rsp.rvalid && axi_req.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st.rsp.arready) begin
            case (ridx)
                `TCR_IDX_CTRL: rbyte = st.ctrl;
                `TCR_IDX_RCAP_LO: rbyte = st.rcap[7:0];
                `TCR_IDX_RCAP_HI: rbyte = st.rcap[15:8];
                `TCR_IDX_CNT_LO: rbyte = st.cnt[7:0];
                `TCR_IDX_CNT_HI: rbyte = st.cnt[15:8];
                `TCR_IDX_IRQ_STAT: rbyte = {6'h00, st.irq_stat};
                `TCR_IDX_IRQ_CLR: rbyte = 8'h00;
                `TCR_IDX_IRQ_EN: rbyte = {6'h00, st.irq_en};
                default: rmap = 1'b0;
            endcase
            if (axi_req.araddr[1:0] != `TCR_BYTE_OFS) begin
                rmap  = 1'b0;
                rbyte = 8'h00;
            end
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rdata  = {`TCR_RDATA_PAD, rbyte};
            next_st.rsp.rresp  = rmap ? `TCR_RESP_OKAY : `TCR_RESP_SLVERR;
        end

        // One transaction of each kind at a time: ready only while nothing is pending.
        next_st.rsp.awready = !next_st.aw_have && !next_st.rsp.bvalid;
        next_st.rsp.wready  = !next_st.w_have && !next_st.rsp.bvalid;
        next_st.rsp.arready = !next_st.rsp.rvalid;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign axi_rsp      = st.rsp;
    assign rx_baud_tick = st.rx_baud_tick;
    assign tx_baud_tick = st.tx_baud_tick;
    assign irq          = st.irq;

    sequence s_wrap_reload;
        wrap && (baud || !st.ctrl.capture_reload_select) && !ext_act;
    endsequence

    sequence s_loaded;
        st.cnt == $past(st.rcap);
    endsequence

    property p_ovf_set;
        @(posedge clock) disable iff (!rstn)
        wrap && !baud |=> st.ctrl.ovf_flag;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_ovf_hold;
        @(posedge clock) disable iff (!rstn)
        st.ctrl.ovf_flag && !wr_ctrl |=> st.ctrl.ovf_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");

    property p_ovf_baud;
        @(posedge clock) disable iff (!rstn)
        !st.ctrl.ovf_flag && !wr_ctrl && (baud || !wrap) |=> !st.ctrl.ovf_flag;
    endproperty
    a_ovf_baud: assert property (p_ovf_baud) else $error("overflow flag set in baud use");

    property p_ext_flag;
        @(posedge clock) disable iff (!rstn)
        ext_act |=> st.ctrl.ext_flag && st.irq_stat[`TCR_IRQ_EXT];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("edge flag not set");

    property p_rx_sel;
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> rx_baud_tick == ($past(st.ctrl.rx_baud_select) ? $past(wrap) : $past(timer1_ovf));
    endproperty
    a_rx_sel: assert property (p_rx_sel) else $error("receive baud source wrong");

    property p_tx_sel;
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> tx_baud_tick == ($past(st.ctrl.tx_baud_select) ? $past(wrap) : $past(timer1_ovf));
    endproperty
    a_tx_sel: assert property (p_tx_sel) else $error("transmit baud source wrong");

    property p_trig_gate;
        @(posedge clock) disable iff (!rstn)
        trig_fall && (baud || !st.ctrl.ext_pin_enable) |-> !ext_act;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger acted while disarmed");

    property p_stop;
        @(posedge clock) disable iff (!rstn)
        !st.ctrl.run_control && !do_wr && !ext_act |=> $stable(st.cnt);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");

    property p_timer_rate;
        @(posedge clock) disable iff (!rstn)
        tick && !st.ctrl.counter_timer_select |=> !tick;
    endproperty
    a_timer_rate: assert property (p_timer_rate) else $error("timer ticked twice in a row");

    property p_counter_tick;
        @(posedge clock) disable iff (!rstn)
        st.ctrl.run_control && st.ctrl.counter_timer_select && cnt_fall |-> tick;
    endproperty
    a_counter_tick: assert property (p_counter_tick) else $error("pin edge not counted");

    property p_reload;
        @(posedge clock) disable iff (!rstn)
        s_wrap_reload |=> s_loaded;
    endproperty
    a_reload: assert property (p_reload) else $error("overflow did not reload");

    property p_capture;
        @(posedge clock) disable iff (!rstn)
        ext_act && st.ctrl.capture_reload_select |=> st.rcap == $past(st.cnt);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed the count");

    property p_capture_wrap;
        @(posedge clock) disable iff (!rstn)
        wrap && !baud && st.ctrl.capture_reload_select |=> st.cnt == `TCR_WORD_RST;
    endproperty
    a_capture_wrap: assert property (p_capture_wrap) else $error("capture mode reloaded");

    property p_ovf_stat;
        @(posedge clock) disable iff (!rstn)
        wrap && !baud |=> st.irq_stat[`TCR_IRQ_OVF];
    endproperty
    a_ovf_stat: assert property (p_ovf_stat) else $error("overflow status not set");

    // Only an acting trigger edge may raise the edge flag; software writes are excluded.
    property p_ext_only;
        @(posedge clock) disable iff (!rstn)
        !ext_act && !wr_ctrl && !st.ctrl.ext_flag |=> !st.ctrl.ext_flag;
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("edge flag set without trigger");

    property p_ext_reload;
        @(posedge clock) disable iff (!rstn)
        ext_act && !st.ctrl.capture_reload_select |=> s_loaded;
    endproperty
    a_ext_reload: assert property (p_ext_reload) else $error("trigger did not reload");

    property p_rcap_hold;
        @(posedge clock) disable iff (!rstn)
        !do_wr && !ext_act |=> $stable(st.rcap);
    endproperty
    a_rcap_hold: assert property (p_rcap_hold) else $error("reload value moved");

    property p_step;
        @(posedge clock) disable iff (!rstn)
        tick && !wrap && !(ext_act && !st.ctrl.capture_reload_select) |=>
            st.cnt == 16'($past(st.cnt) + `TCR_CNT_STEP);
    endproperty
    a_step: assert property (p_step) else $error("count did not advance by one");
endmodule

// >>> tb/tcr_far_model.sv
// Far-side model: count and trigger pins, other-timer overflow source, baud tick counters.
`timescale 1ns/1ps

module tcr_far_model (
    input  wire logic  clock,
    input  wire logic  rstn,
    input  wire logic  count_req,
    input  wire logic  trig_req,
    input  wire logic  t1_en,
    input  wire logic  rx_baud_tick,
    input  wire logic  tx_baud_tick,
    output logic       count_input_pin,
    output logic       ext_trigger_pin,
    output logic       timer1_ovf,
    output logic [15:0] rx_n,
    output logic [15:0] tx_n
);
    logic [2:0] cl;
    logic [2:0] tl;
    logic [3:0] div;

    // Pins idle high; each request holds the pin low for six clocks, well above the sync need.
    assign count_input_pin = (cl == 3'h0);
    assign ext_trigger_pin = (tl == 3'h0);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cl         <= 3'h0;
            tl         <= 3'h0;
            div        <= 4'h0;
            timer1_ovf <= 1'b0;
            rx_n       <= 16'h0000;
            tx_n       <= 16'h0000;
        end else begin
            cl         <= count_req ? 3'h6 : (cl != 3'h0 ? cl - 3'h1 : 3'h0);
            tl         <= trig_req ? 3'h6 : (tl != 3'h0 ? tl - 3'h1 : 3'h0);
            div        <= div + 4'h1;
            timer1_ovf <= t1_en && (div == 4'hF);
            rx_n       <= rx_n + {15'h0000, rx_baud_tick};
            tx_n       <= tx_n + {15'h0000, tx_baud_tick};
        end
    end
endmodule

// >>> tb/timer2_capture_reload_ctrl_tb_top.sv
// Self-checking bench for the capture/reload timer over its AXI4-Lite registers.
`timescale 1ns/1ps
`include "tcr_map.svh"

module timer2_capture_reload_ctrl_tb_top;
    localparam logic [11:0] A_CTRL = {`TCR_IDX_CTRL, 2'h0};
    localparam logic [11:0] A_RLO  = {`TCR_IDX_RCAP_LO, 2'h0};
    localparam logic [11:0] A_RHI  = {`TCR_IDX_RCAP_HI, 2'h0};
    localparam logic [11:0] A_CLO  = {`TCR_IDX_CNT_LO, 2'h0};
    localparam logic [11:0] A_CHI  = {`TCR_IDX_CNT_HI, 2'h0};
    localparam logic [11:0] A_STAT = {`TCR_IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] A_CLR  = {`TCR_IDX_IRQ_CLR, 2'h0};
    localparam logic [11:0] A_EN   = {`TCR_IDX_IRQ_EN, 2'h0};
    localparam logic [11:0] A_BAD  = 12'hFFC;

    logic                  clock;
    logic                  rstn;
    logic                  count_req;
    logic                  trig_req;
    logic                  t1_en;
    tcr_pkg::tcr_axi_req_t req;
    tcr_pkg::tcr_axi_rsp_t rsp;
    logic                  cpin;
    logic                  tpin;
    logic                  t1ovf;
    logic                  rxt;
    logic                  txt;
    logic                  irq;
    logic [15:0]           rx_n;
    logic [15:0]           tx_n;
    logic [15:0]           rx0;
    logic [15:0]           tx0;
    logic [31:0]           d;
    logic [1:0]            r;
    int                    err_count;
    int                    checks;
    int                    m;
    logic [11:0]           rst_addr [7];

    tcr_top u_tcr_top (.clock(clock), .rstn(rstn), .axi_req(req), .axi_rsp(rsp),
        .count_input_pin(cpin), .ext_trigger_pin(tpin), .timer1_ovf(t1ovf),
        .rx_baud_tick(rxt), .tx_baud_tick(txt), .irq(irq));

    tcr_far_model u_tcr_far_model (.clock(clock), .rstn(rstn), .count_req(count_req),
        .trig_req(trig_req), .t1_en(t1_en), .rx_baud_tick(rxt), .tx_baud_tick(txt),
        .count_input_pin(cpin), .ext_trigger_pin(tpin), .timer1_ovf(t1ovf),
        .rx_n(rx_n), .tx_n(tx_n));

    task automatic end_of_test();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Handshakes are judged at the rising edge itself, before the design's registers move,
    // and every change follows that edge, so each request stands until its own ready.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int n;
        @(posedge clock);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= v;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
            if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
            if (rsp.bvalid && req.bready) begin
                req.bready <= 1'b0;
                break;
            end
        end
        if (n == 100) begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge clock);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) begin
                req.rready <= 1'b0;
                d = rsp.rdata;
                r = rsp.rresp;
                break;
            end
        end
        if (n == 100) begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask

    // One falling edge on the chosen pin, then enough clocks for sync and effect.
    task automatic fall(input bit trig);
        @(posedge clock);
        if (trig) trig_req <= 1'b1;
        else count_req <= 1'b1;
        @(posedge clock);
        trig_req  <= 1'b0;
        count_req <= 1'b0;
        repeat (14) @(posedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        rstn = 1'b0; req = '0; count_req = 1'b0; trig_req = 1'b0; t1_en = 1'b0;
        err_count = 0; checks = 0;
        rst_addr = '{A_CTRL, A_RLO, A_RHI, A_CLO, A_CHI, A_STAT, A_EN};
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        foreach (rst_addr[i]) rdchk(rst_addr[i], 32'h00000000);
        rd(A_BAD);
        chk(r, `TCR_RESP_SLVERR);
        wr(A_RLO, 32'h00000034);
        wr(A_RHI, 32'h00000012);
        rdchk(A_RLO, 32'h00000034);
        rdchk(A_RHI, 32'h00000012);
        wr(A_EN, 32'h00000001);
        wr(A_CTRL, 32'h00000004);
        repeat (100) @(posedge clock);
        wr(A_CTRL, 32'h00000000);
        rd(A_CLO);
        chk(d >= 32'd48 && d <= 32'd58, 1);
        for (m = 0; m < 2; m++) begin
            wr(A_CTRL, 32'h00000000);
            wr(A_CLO, 32'h000000F0);
            wr(A_CHI, 32'h000000FF);
            wr(A_CTRL, 32'h00000004 | m);
            repeat (40) @(posedge clock);
            rdchk(A_CTRL, 32'h00000084 | m);
            rdchk(A_CHI, m ? 32'h00000000 : 32'h00000012);
            chk(irq, 1);
            wr(A_CLR, 32'h00000003);
        end
        wr(A_CTRL, 32'h00000000);
        rdchk(A_CTRL, 32'h00000000);
        wr(A_CLO, 32'h0000005A);
        wr(A_CHI, 32'h00000000);
        wr(A_CTRL, 32'h00000009);
        fall(1'b1);
        rdchk(A_RLO, 32'h0000005A);
        rdchk(A_CTRL, 32'h00000049);
        // The capture above also took the high byte, so the reload value is rebuilt in full.
        wr(A_RLO, 32'h00000034);
        wr(A_RHI, 32'h00000012);
        wr(A_CTRL, 32'h00000008);
        wr(A_CLO, 32'h00000000);
        fall(1'b1);
        rdchk(A_CLO, 32'h00000034);
        rdchk(A_CHI, 32'h00000012);
        wr(A_CTRL, 32'h00000000);
        wr(A_CLO, 32'h00000000);
        wr(A_CHI, 32'h00000000);
        wr(A_CTRL, 32'h00000006);
        repeat (3) fall(1'b0);
        rdchk(A_CLO, 32'h00000003);
        wr(A_CTRL, 32'h00000002);
        fall(1'b0);
        rdchk(A_CLO, 32'h00000003);
        wr(A_CLO, 32'h000000FE);
        wr(A_CHI, 32'h000000FF);
        rx0 = rx_n;
        tx0 = tx_n;
        wr(A_CTRL, 32'h0000002D);
        fall(1'b1);
        repeat (20) @(posedge clock);
        rdchk(A_CTRL, 32'h0000002D);
        rdchk(A_CHI, 32'h00000012);
        chk(rx_n - rx0, 16'h0001);
        chk(tx_n - tx0, 16'h0000);
        wr(A_CTRL, 32'h00000000);
        rx0 = rx_n;
        tx0 = tx_n;
        t1_en <= 1'b1;
        repeat (64) @(posedge clock);
        t1_en <= 1'b0;
        repeat (4) @(posedge clock);
        chk(rx_n - rx0, tx_n - tx0);
        chk(tx_n != tx0, 1);
        wr(A_CLR, 32'h00000003);
        rdchk(A_STAT, 32'h00000000);
        chk(irq, 0);
        end_of_test();
    end
endmodule
